// ### rtl/irq_route_pkg.sv
// shared constants and source bundles for the dual-core interrupt routing block
`default_nettype none
package irq_route_pkg;
  localparam int HOST_SRC_W = 32;
  localparam int DSP_SRC_W = 14;
  localparam int HOST_SOFT_W = 4;
  localparam int DSP_SOFT_W = 2;
  // host source positions
  localparam int HOST_POS_SOFT3 = 31;
  localparam int HOST_POS_SOFT2 = 30;
  localparam int HOST_POS_SOFT1 = 29;
  localparam int HOST_POS_DSP = 28;
  localparam int HOST_POS_DISPLAY = 27;
  localparam int HOST_POS_RTC = 8;
  localparam int HOST_POS_MAILBOX0 = 7;
  localparam int HOST_POS_SOFT0 = 6;
  localparam int HOST_POS_TIMER0_CH0 = 2;
  localparam int HOST_POS_SERIAL0 = 0;
  // dsp source positions
  localparam int DSP_POS_SOFT1 = 13;
  localparam int DSP_POS_PWM0 = 11;
  localparam int DSP_POS_TIMER1 = 6;
  localparam int DSP_POS_USB = 0;
  // values after reset
  localparam logic [HOST_SRC_W-1:0] HOST_PEND_RST = 32'h0000_0000;
  localparam logic [HOST_SRC_W-1:0] HOST_PREV_RST = 32'h0000_0000;
  localparam logic [DSP_SRC_W-1:0] DSP_PREV_RST = 14'h0000;
  localparam logic [DSP_SRC_W-1:0] DSP_OUT_RST = 14'h0000;
  localparam logic IRQ_RST = 1'b0;

  // hardware requests toward the host controller, high end first
  typedef struct packed {
    logic dsp_core;
    logic display_controller;
    logic nand_ctrl;
    logic second_bus_dma;
    logic camera_input_port;
    logic gpio1_ab;
    logic converter;
    logic [3:0] pwm;
    logic usb_host_ctrl;
    logic usb_device_ctrl;
    logic audio_serial;
    logic two_wire;
    logic bus_bridge_dma;
    logic first_bus_dma;
    logic spi_master;
    logic memory_card;
    logic system_control_unit;
    logic rtc;
    logic mailbox0;
    logic gpio0_ab;
    logic [2:0] timer_group_zero;
    logic serial_port_one;
    logic serial_port_zero;
  } host_src_s;

  // hardware requests toward the signal processor
  typedef struct packed {
    logic pwm0;
    logic gpio0_cd;
    logic fast_converter;
    logic display_controller;
    logic camera_input_port;
    logic timer_group_one;
    logic timer_group_zero;
    logic mailbox1;
    logic second_bus_dma;
    logic bus_bridge_dma;
    logic first_bus_dma;
    logic usb_host_ctrl;
    logic usb_device_ctrl;
  } dsp_src_s;
endpackage
`default_nettype wire

// ### rtl/dual_core_irq_route.sv
// host and signal-processor interrupt routing with trigger qualification
`default_nettype none
module dual_core_irq_route (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire irq_route_pkg::host_src_s HOST_SRC_IN,
  input wire logic [irq_route_pkg::HOST_SOFT_W-1:0] HOST_SOFT_IN,
  input wire logic [irq_route_pkg::HOST_SRC_W-1:0] HOST_EDGE_MODE_IN,
  input wire logic [irq_route_pkg::HOST_SRC_W-1:0] HOST_ENABLE_IN,
  input wire logic [irq_route_pkg::HOST_SRC_W-1:0] HOST_ACK_IN,
  input wire irq_route_pkg::dsp_src_s DSP_SRC_IN,
  input wire logic [irq_route_pkg::DSP_SOFT_W-1:0] DSP_SOFT_IN,
  input wire logic HOST_NMI_REQ_IN,
  output logic HOST_IRQ_OUT,
  output logic [irq_route_pkg::HOST_SRC_W-1:0] HOST_PENDING_OUT,
  output logic [irq_route_pkg::DSP_SRC_W-1:0] DSP_IRQ_OUT,
  output logic DSP_NMI_OUT
);
  logic [irq_route_pkg::HOST_SRC_W-1:0] host_raw;
  logic [irq_route_pkg::HOST_SRC_W-1:0] host_rise;
  logic [irq_route_pkg::HOST_SRC_W-1:0] host_prev_q, host_prev_d;
  logic [irq_route_pkg::HOST_SRC_W-1:0] host_edge_q, host_edge_d;
  logic [irq_route_pkg::HOST_SRC_W-1:0] host_pend;
  logic host_irq_q, host_irq_d;
  logic [irq_route_pkg::DSP_SRC_W-1:0] dsp_raw;
  logic [irq_route_pkg::DSP_SRC_W-1:0] dsp_prev_q, dsp_prev_d;
  logic [irq_route_pkg::DSP_SRC_W-1:0] dsp_out_q, dsp_out_d;
  logic nmi_q, nmi_d;
  logic rst_dly_q, rst_dly_d;

  // host vector, bit 31 at the top; software slots have no pin behind them
  assign host_raw = {HOST_SOFT_IN[3:1],
                     HOST_SRC_IN.dsp_core, HOST_SRC_IN.display_controller,
                     HOST_SRC_IN.nand_ctrl, HOST_SRC_IN.second_bus_dma,
                     HOST_SRC_IN.camera_input_port, HOST_SRC_IN.gpio1_ab,
                     HOST_SRC_IN.converter, HOST_SRC_IN.pwm,
                     HOST_SRC_IN.usb_host_ctrl, HOST_SRC_IN.usb_device_ctrl,
                     HOST_SRC_IN.audio_serial, HOST_SRC_IN.two_wire,
                     HOST_SRC_IN.bus_bridge_dma, HOST_SRC_IN.first_bus_dma,
                     HOST_SRC_IN.spi_master, HOST_SRC_IN.memory_card,
                     HOST_SRC_IN.system_control_unit, HOST_SRC_IN.rtc,
                     HOST_SRC_IN.mailbox0, HOST_SOFT_IN[0],
                     HOST_SRC_IN.gpio0_ab, HOST_SRC_IN.timer_group_zero,
                     HOST_SRC_IN.serial_port_one, HOST_SRC_IN.serial_port_zero};

  // active-high sources, so a request edge is a low-to-high step
  assign host_rise = host_raw & ~host_prev_q;

  // edge latch: a new edge beats an acknowledge in the same cycle
  always_comb begin
    host_prev_d = host_raw;
    host_edge_d = (host_edge_q & ~HOST_ACK_IN) | host_rise;
    host_pend = (host_edge_d & HOST_EDGE_MODE_IN) | (host_raw & ~HOST_EDGE_MODE_IN);
    host_irq_d = |(host_pend & HOST_ENABLE_IN);
    rst_dly_d = RST_IN; // keeps checks quiet one cycle past reset
  end

  // host state registers
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      host_prev_q <= irq_route_pkg::HOST_PREV_RST;
      host_edge_q <= irq_route_pkg::HOST_PEND_RST;
      host_irq_q <= irq_route_pkg::IRQ_RST;
      HOST_PENDING_OUT <= irq_route_pkg::HOST_PEND_RST;
      rst_dly_q <= 1'b1;
    end else begin
      rst_dly_q <= rst_dly_d;
      host_prev_q <= host_prev_d;
      host_edge_q <= host_edge_d;
      host_irq_q <= host_irq_d;
      HOST_PENDING_OUT <= host_pend;
    end
  end

  assign HOST_IRQ_OUT = host_irq_q;

  // dsp vector; usb host and device share one slot through an or
  assign dsp_raw = {DSP_SOFT_IN,
                    DSP_SRC_IN.pwm0, DSP_SRC_IN.gpio0_cd, DSP_SRC_IN.fast_converter,
                    DSP_SRC_IN.display_controller, DSP_SRC_IN.camera_input_port,
                    DSP_SRC_IN.timer_group_one, DSP_SRC_IN.timer_group_zero,
                    DSP_SRC_IN.mailbox1, DSP_SRC_IN.second_bus_dma,
                    DSP_SRC_IN.bus_bridge_dma, DSP_SRC_IN.first_bus_dma,
                    DSP_SRC_IN.usb_host_ctrl | DSP_SRC_IN.usb_device_ctrl};

  // edge only: a source held high gives one pulse; one-clock highs still count
  always_comb begin
    dsp_prev_d = dsp_raw;
    dsp_out_d = dsp_raw & ~dsp_prev_q;
    nmi_d = HOST_NMI_REQ_IN;
  end

  // dsp state registers
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      dsp_prev_q <= irq_route_pkg::DSP_PREV_RST;
      dsp_out_q <= irq_route_pkg::DSP_OUT_RST;
      nmi_q <= irq_route_pkg::IRQ_RST;
    end else begin
      dsp_prev_q <= dsp_prev_d;
      dsp_out_q <= dsp_out_d;
      nmi_q <= nmi_d;
    end
  end

  assign DSP_IRQ_OUT = dsp_out_q;
  assign DSP_NMI_OUT = nmi_q;

  // checks, off during reset and the cycle after it
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN || rst_dly_q);

  sequence s_edge_ack;
    (|(host_rise & HOST_ACK_IN & HOST_EDGE_MODE_IN));
  endsequence
  sequence s_edge_seen;
    (host_edge_q & $past(host_rise & HOST_ACK_IN)) == $past(host_rise & HOST_ACK_IN);
  endsequence

  a_irq_asserts: assert property ((|(host_pend & HOST_ENABLE_IN)) |=> HOST_IRQ_OUT)
    else $error("host request missing for enabled pending source");
  a_irq_clears: assert property (!(|(host_pend & HOST_ENABLE_IN)) |=> !HOST_IRQ_OUT)
    else $error("host request high with nothing pending");
  a_set_wins: assert property (s_edge_ack |=> s_edge_seen)
    else $error("edge lost against acknowledge");
  a_level_follow: assert property (1'b1 |=> ((HOST_PENDING_OUT & ~$past(HOST_EDGE_MODE_IN))
      == ($past(host_raw) & ~$past(HOST_EDGE_MODE_IN))))
    else $error("level source pending does not follow input");
  a_soft_slots: assert property (host_raw[irq_route_pkg::HOST_POS_SOFT3] == HOST_SOFT_IN[3]
      && host_raw[irq_route_pkg::HOST_POS_SOFT0] == HOST_SOFT_IN[0])
    else $error("software slot not fed from software input");
  a_host_map: assert property (host_raw[irq_route_pkg::HOST_POS_DSP] == HOST_SRC_IN.dsp_core
      && host_raw[irq_route_pkg::HOST_POS_MAILBOX0] == HOST_SRC_IN.mailbox0
      && host_raw[irq_route_pkg::HOST_POS_SERIAL0] == HOST_SRC_IN.serial_port_zero
      && host_raw[irq_route_pkg::HOST_POS_RTC] == HOST_SRC_IN.rtc)
    else $error("host source in wrong position");
  a_dsp_edge: assert property (!dsp_raw[irq_route_pkg::DSP_POS_PWM0]
      ##1 dsp_raw[irq_route_pkg::DSP_POS_PWM0] |=> DSP_IRQ_OUT[irq_route_pkg::DSP_POS_PWM0]
      ##1 !DSP_IRQ_OUT[irq_route_pkg::DSP_POS_PWM0])
    else $error("dsp edge not reported as one pulse");
  a_dsp_no_level: assert property (dsp_raw[irq_route_pkg::DSP_POS_TIMER1] [*2]
      |=> !DSP_IRQ_OUT[irq_route_pkg::DSP_POS_TIMER1])
    else $error("dsp held level retriggered");
  a_usb_or: assert property (dsp_raw[irq_route_pkg::DSP_POS_USB]
      == (DSP_SRC_IN.usb_host_ctrl | DSP_SRC_IN.usb_device_ctrl))
    else $error("usb slot is not the or of host and device");
  a_nmi_follow: assert property (DSP_NMI_OUT == $past(HOST_NMI_REQ_IN))
    else $error("nmi does not follow host core request");
endmodule
`default_nettype wire

// ### bench/irq_src_model.sv
// far-side model: peripherals, software slots and cores raising requests
`default_nettype none
module irq_src_model (
  input wire logic [31:0] host_req_in,
  input wire logic [13:0] dsp_req_in,
  input wire logic usb_pick_in,
  output var irq_route_pkg::host_src_s host_src_out,
  output logic [3:0] host_soft_out,
  output var irq_route_pkg::dsp_src_s dsp_src_out,
  output logic [1:0] dsp_soft_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // position-indexed requests onto the wiring; levels are active high
  // the bench holds each request over at least one full clock
  always_comb begin
    for (int b = 0; b < 28; b++) begin
      host_src_out[b] = host_req_in[b < 6 ? b : b + 1]; // position 6 is software only
    end
    host_soft_out = {host_req_in[31:29], host_req_in[6]};
    dsp_src_out[12:2] = dsp_req_in[11:1];
    // usb host and device share position 0; pick chooses which one raises it
    dsp_src_out[1] = dsp_req_in[0] & usb_pick_in;
    dsp_src_out[0] = dsp_req_in[0] & ~usb_pick_in;
    dsp_soft_out = dsp_req_in[13:12];
  end
endmodule
`default_nettype wire

// ### bench/dual_core_irq_route_bench.sv
// self-checking bench for the dual-core interrupt routing block
`default_nettype none
module dual_core_irq_route_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic nmi = 1'b0;
  logic pick = 1'b0;
  logic [31:0] hreq = '0, mode = '0, en = '0, ack = '0;
  logic [13:0] dreq = '0;
  irq_route_pkg::host_src_s hsrc;
  irq_route_pkg::dsp_src_s dsrc;
  logic [3:0] hsoft;
  logic [1:0] dsoft;
  logic irq;
  logic dnmi;
  logic [31:0] pend;
  logic [13:0] dirq;
  int fail_count = 0;
  int tests_run = 0;
  typedef struct {logic [31:0] req; logic [31:0] en; logic irq;} row_s;
  // level-mode rows: pending follows the request, irq needs an enabled one
  row_s rows[4] = '{'{32'h0000_0001, 32'hffff_ffff, 1'h1},
    '{32'h8000_0040, 32'h0000_0000, 1'h0},
    '{32'h1000_0040, 32'h0000_0040, 1'h1},
    '{32'h0000_0000, 32'hffff_ffff, 1'h0}};

  irq_src_model src_u (.host_req_in(hreq), .dsp_req_in(dreq), .usb_pick_in(pick),
    .host_src_out(hsrc), .host_soft_out(hsoft), .dsp_src_out(dsrc), .dsp_soft_out(dsoft));
  dual_core_irq_route dut_u (.CLK_IN(clk), .RST_IN(rst), .HOST_SRC_IN(hsrc),
    .HOST_SOFT_IN(hsoft), .HOST_EDGE_MODE_IN(mode), .HOST_ENABLE_IN(en), .HOST_ACK_IN(ack),
    .DSP_SRC_IN(dsrc), .DSP_SOFT_IN(dsoft), .HOST_NMI_REQ_IN(nmi), .HOST_IRQ_OUT(irq),
    .HOST_PENDING_OUT(pend), .DSP_IRQ_OUT(dirq), .DSP_NMI_OUT(dnmi));

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;

  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic chk_host(input logic [31:0] p, input logic i);
    tests_run++;
    if (pend !== p || irq !== i) begin
      fail_count++;
      $display("Error at %0t: host pend %h irq %b, want %h %b", $time, pend, irq, p, i);
    end
  endtask
  task automatic chk_dsp(input logic [13:0] d, input logic n);
    tests_run++;
    if (dirq !== d || dnmi !== n) begin
      fail_count++;
      $display("Error at %0t: dsp irq %h nmi %b, want %h %b", $time, dirq, dnmi, d, n);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 135 cycles
  initial begin
    repeat (1000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc();
    chk_host(32'h0, 1'h0);
    chk_dsp(14'h0, 1'h0);
    foreach (rows[r]) begin
      @(posedge clk);
      hreq <= rows[r].req;
      en <= rows[r].en;
      cyc();
      chk_host(rows[r].req, rows[r].irq);
    end
    // walking one shows every host position lands in its own slot
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      hreq <= 32'h1 << i;
      cyc();
      chk_host(32'h1 << i, 1'h1);
    end
    // edge mode on position 3: latch, hold past the source, edge beats ack
    @(posedge clk);
    hreq <= 32'h0;
    mode <= 32'h0000_0008;
    cyc();
    @(posedge clk);
    hreq <= 32'h0000_0008;
    cyc();
    chk_host(32'h0000_0008, 1'h1);
    @(posedge clk);
    hreq <= 32'h0;
    cyc();
    chk_host(32'h0000_0008, 1'h1);
    @(posedge clk);
    hreq <= 32'h0000_0008;
    ack <= 32'h0000_0008;
    cyc();
    chk_host(32'h0000_0008, 1'h1);
    // ack still high with the source steady: the latch now clears
    cyc();
    chk_host(32'h0, 1'h0);
    @(posedge clk);
    ack <= 32'h0;
    // dsp walk: one pulse per rising edge, none for a held level
    for (int i = 0; i < 15; i++) begin
      @(posedge clk);
      dreq <= 14'h1 << (i % 14);
      pick <= (i == 14);
      nmi <= i[0];
      cyc();
      chk_dsp(14'h1 << (i % 14), i[0]);
      cyc();
      chk_dsp(14'h0, i[0]);
    end
    // reset in mid-run clears everything even with sources raised
    @(posedge clk);
    hreq <= 32'h0000_0004;
    dreq <= 14'h0002;
    rst <= 1'b1;
    cyc();
    chk_host(32'h0, 1'h0);
    chk_dsp(14'h0, 1'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
